/* File: shared/hlt_pkg.sv */
// package: register offsets, field positions, reset values, encodings of the limit timer
// assumes an apb slave with 32-bit data, one aligned word per register
package hlt_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] HLT_OFF_COUNT    = 8'h00;
	localparam logic [7:0] HLT_OFF_PERIOD   = 8'h04;
	localparam logic [7:0] HLT_OFF_CONTROL0 = 8'h08;
	localparam logic [7:0] HLT_OFF_CONTROL1 = 8'h0C;
	localparam logic [7:0] HLT_OFF_INT_FLAG = 8'h10;
	localparam logic [7:0] HLT_OFF_INT_EN   = 8'h14;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int HLT_C0_PRESCALE_LSB  = 0;
	localparam int HLT_C0_POSTSCALE_LSB = 3;
	localparam int HLT_C1_SOURCE_LSB    = 0;
	localparam int HLT_C1_RISE_EN_BIT   = 3;
	localparam int HLT_C1_FALL_EN_BIT   = 4;
	localparam int HLT_C1_RISE_EDGE_BIT = 5;
	localparam int HLT_C1_FALL_EDGE_BIT = 6;
	localparam int HLT_FLAG_BIT         = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] HLT_COUNT_RESET    = 8'h00;
	localparam logic [7:0] HLT_PERIOD_RESET   = 8'hFF;
	localparam logic [6:0] HLT_CONTROL0_RESET = 7'h00;
	localparam logic [6:0] HLT_CONTROL1_RESET = 7'h00;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		HLT_PRE_DIV1  = 2'b00,
		HLT_PRE_DIV4  = 2'b01,
		HLT_PRE_DIV16 = 2'b10,
		HLT_PRE_DIV64 = 2'b11
	} hlt_prescale_t;

	localparam logic [2:0] HLT_SRC_CCP    = 3'h0;
	localparam logic [2:0] HLT_SRC_CMP1   = 3'h1;
	localparam logic [2:0] HLT_SRC_CMP2   = 3'h2;
	localparam logic [2:0] HLT_SRC_FAULT  = 3'h3;
	localparam logic [2:0] HLT_SRC_OUT0   = 3'h4;
	localparam logic [2:0] HLT_SRC_OUT1   = 3'h5;

	// prescale terminal counts (ticks - 1)
	localparam logic [5:0] HLT_PRE_TC1  = 6'h00;
	localparam logic [5:0] HLT_PRE_TC4  = 6'h03;
	localparam logic [5:0] HLT_PRE_TC16 = 6'h0F;
	localparam logic [5:0] HLT_PRE_TC64 = 6'h3F;

endpackage : hlt_pkg

/* File: shared/hlt_cfg_if.sv */
// interface: configuration and strobes passed from the register file to the counter core
// assumes one clock domain, driven by the top module
`timescale 1ns/1ns
`default_nettype none
interface hlt_cfg_if;
	logic [1:0] prescale_select;
	logic [3:0] postscale_select;
	logic [7:0] period;
	logic       count_write;
	logic [7:0] count_wdata;
	logic       scaler_clear;
	logic       ext_reset;
	logic [7:0] count;
	logic       match;
	logic       post_overflow;

	modport regs
	(
		output prescale_select,
		output postscale_select,
		output period,
		output count_write,
		output count_wdata,
		output scaler_clear,
		output ext_reset,
		input  count,
		input  match,
		input  post_overflow
	);

	modport core
	(
		input  prescale_select,
		input  postscale_select,
		input  period,
		input  count_write,
		input  count_wdata,
		input  scaler_clear,
		input  ext_reset,
		output count,
		output match,
		output post_overflow
	);
endinterface : hlt_cfg_if
`default_nettype wire

/* File: design/hlt_reset_detect.sv */
// module: peripheral reset source selection and level/edge detection
// assumes source inputs synchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
module hlt_reset_detect
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic [5:0] sources,
	input  wire logic [2:0] source_select,
	input  wire logic       rise_enable,
	input  wire logic       fall_enable,
	input  wire logic       rise_edge_mode,
	input  wire logic       fall_edge_mode,
	output logic            reset_event
);
	logic prev_level;
	wire  valid_source;
	wire  level;
	wire  rise_hit;
	wire  fall_hit;

	assign valid_source = (source_select <= hlt_pkg::HLT_SRC_OUT1);
	assign level        = valid_source & sources[source_select];
	assign rise_hit     = rise_enable & (rise_edge_mode ? (level & ~prev_level) : level);
	assign fall_hit     = fall_enable & (fall_edge_mode ? (~level & prev_level) : ~level);
	assign reset_event  = valid_source & (rise_hit | fall_hit);

	always_ff @(posedge core_clk)
	begin
		if (rst)
			prev_level <= 1'b0;
		else if (clk_en)
			prev_level <= level;
	end
endmodule : hlt_reset_detect
`default_nettype wire

/* File: design/hlt_core.sv */
// module: prescaler, count, period match and postscaler
// assumes strobes from the register file, one core_clk domain
`timescale 1ns/1ns
`default_nettype none
module hlt_core
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic sleep,
	hlt_cfg_if.core   cfg
);
	logic [5:0] pre_count;
	logic [3:0] post_count;
	logic       reset_pending;
	logic [5:0] pre_tc;
	wire        tick;
	wire        run;

	assign run = clk_en & ~sleep;

	always_comb
	begin
		case (hlt_pkg::hlt_prescale_t'(cfg.prescale_select))
			hlt_pkg::HLT_PRE_DIV1:  pre_tc = hlt_pkg::HLT_PRE_TC1;
			hlt_pkg::HLT_PRE_DIV4:  pre_tc = hlt_pkg::HLT_PRE_TC4;
			hlt_pkg::HLT_PRE_DIV16: pre_tc = hlt_pkg::HLT_PRE_TC16;
			hlt_pkg::HLT_PRE_DIV64: pre_tc = hlt_pkg::HLT_PRE_TC64;
			default:                pre_tc = hlt_pkg::HLT_PRE_TC1;
		endcase
	end

	assign tick      = (pre_count == pre_tc);
	assign cfg.match = (cfg.count == cfg.period);
	assign cfg.post_overflow = run & tick & cfg.match & ~cfg.count_write & ~cfg.scaler_clear
		& (post_count == cfg.postscale_select);

	// prescaler
	always_ff @(posedge core_clk)
	begin
		if (rst)
			pre_count <= 6'h00;
		else if (cfg.scaler_clear)
			pre_count <= 6'h00;
		else if (run)
			pre_count <= tick ? 6'h00 : pre_count + 6'h01;
	end

	// count register; software writes land even while asleep
	always_ff @(posedge core_clk)
	begin
		if (rst)
			cfg.count <= hlt_pkg::HLT_COUNT_RESET;
		else if (cfg.count_write)
			cfg.count <= cfg.count_wdata;
		else if (run & tick & (reset_pending | cfg.ext_reset))
			cfg.count <= 8'h00;
		else if (run & tick & cfg.match)
			cfg.count <= 8'h00;
		else if (run & tick)
			cfg.count <= cfg.count + 8'h01;
	end

	// reset event held until the next timer clock edge
	always_ff @(posedge core_clk)
	begin
		if (rst)
			reset_pending <= 1'b0;
		else if (cfg.count_write | (run & tick))
			reset_pending <= 1'b0;
		else if (run & cfg.ext_reset)
			reset_pending <= 1'b1;
	end

	// postscaler
	always_ff @(posedge core_clk)
	begin
		if (rst)
			post_count <= 4'h0;
		else if (cfg.scaler_clear | cfg.count_write)
			post_count <= 4'h0;
		else if (cfg.post_overflow)
			post_count <= 4'h0;
		else if (run & tick & cfg.match)
			post_count <= post_count + 4'h1;
	end
endmodule : hlt_core
`default_nettype wire

/* File: design/hlt_top.sv */
// module: limit timer top with apb register slave
// assumes apb master on core_clk; sources synchronous; rst covers every device reset
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - count advances on each prescaled instruction clock edge
// - prescaler divides by 1, 4, 16 or 64 via two-bit select
// - count compared with period every timer clock; equality gives match
// - after match count returns to zero and postscaler advances
// - count and period read/write; reset clears count, sets period all ones
// - prescaler and postscaler clear on count or control0 write and reset
// - control0 write leaves count unchanged
// - postscaler overflow sets the limit match flag
// - interrupt request only when flag and enable both set
// - four-bit postscale select gives ratios 1:1 to 1:16
// - enabled peripheral reset clears count; a coincident match still advances the postscaler
// - three-bit field in control1 selects one of six reset sources
// - separate enables for high and low reset conditions
// - mode bits make each reset condition edge sensitive, else level
// - count clears on first timer clock edge after reset event
// - software count write beats coincident reset and discards pending ones
// - unscaled match output goes to the output generator
// - timer frozen and count held during sleep
module hlt_top
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic        sleep,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        capture_compare_unit,
	input  wire logic        comparator1_out,
	input  wire logic        comparator2_out,
	input  wire logic        output_generator_fault_pin,
	input  wire logic        output_generator_out0,
	input  wire logic        output_generator_out1,
	output logic             limit_match,
	output logic             limit_irq
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [6:0] limit_control0;
	logic [6:0] limit_control1;
	logic [7:0] limit_period;
	logic       limit_match_flag;
	logic       limit_match_int_enable;

	hlt_cfg_if cfg ();

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	wire access   = psel & penable;
	wire wr       = access & pwrite & clk_en;
	wire sel_cnt  = (paddr == hlt_pkg::HLT_OFF_COUNT);
	wire sel_per  = (paddr == hlt_pkg::HLT_OFF_PERIOD);
	wire sel_c0   = (paddr == hlt_pkg::HLT_OFF_CONTROL0);
	wire sel_c1   = (paddr == hlt_pkg::HLT_OFF_CONTROL1);
	wire sel_flg  = (paddr == hlt_pkg::HLT_OFF_INT_FLAG);
	wire sel_ien  = (paddr == hlt_pkg::HLT_OFF_INT_EN);
	wire mapped   = sel_cnt | sel_per | sel_c0 | sel_c1 | sel_flg | sel_ien;
	wire wr_c0    = wr & sel_c0;

	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (sel_cnt)
			rd_mux = {24'h000000, cfg.count};
		else if (sel_per)
			rd_mux = {24'h000000, limit_period};
		else if (sel_c0)
			rd_mux = {25'h0000000, limit_control0};
		else if (sel_c1)
			rd_mux = {25'h0000000, limit_control1};
		else if (sel_flg)
			rd_mux = {31'h00000000, limit_match_flag};
		else if (sel_ien)
			rd_mux = {31'h00000000, limit_match_int_enable};
	end
	assign prdata = rd_mux;

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			limit_control0         <= hlt_pkg::HLT_CONTROL0_RESET;
			limit_control1         <= hlt_pkg::HLT_CONTROL1_RESET;
			limit_period           <= hlt_pkg::HLT_PERIOD_RESET;
			limit_match_int_enable <= 1'b0;
		end
		else if (wr)
		begin
			if (sel_c0)
				limit_control0 <= pwdata[6:0];
			if (sel_c1)
				limit_control1 <= pwdata[6:0];
			if (sel_per)
				limit_period <= pwdata[7:0];
			if (sel_ien)
				limit_match_int_enable <= pwdata[hlt_pkg::HLT_FLAG_BIT];
		end
	end

	// flag: hardware set wins over software write of zero
	always_ff @(posedge core_clk)
	begin
		if (rst)
			limit_match_flag <= 1'b0;
		else if (cfg.post_overflow)
			limit_match_flag <= 1'b1;
		else if (wr & sel_flg)
			limit_match_flag <= pwdata[hlt_pkg::HLT_FLAG_BIT];
	end

	assign limit_irq   = limit_match_flag & limit_match_int_enable;
	assign limit_match = cfg.match;

	// ------------------------------------------------------------
	// core connections
	// ------------------------------------------------------------
	assign cfg.prescale_select  = limit_control0[hlt_pkg::HLT_C0_PRESCALE_LSB +: 2];
	assign cfg.postscale_select = limit_control0[hlt_pkg::HLT_C0_POSTSCALE_LSB +: 4];
	assign cfg.period           = limit_period;
	assign cfg.count_write      = wr & sel_cnt;
	assign cfg.count_wdata      = pwdata[7:0];
	assign cfg.scaler_clear     = wr_c0 | (wr & sel_cnt);

	wire [5:0] sources = {output_generator_out1, output_generator_out0,
		output_generator_fault_pin, comparator2_out, comparator1_out, capture_compare_unit};

	hlt_reset_detect u_detect
	(
		.core_clk       (core_clk),
		.rst            (rst),
		.clk_en         (clk_en & ~sleep),
		.sources        (sources),
		.source_select  (limit_control1[hlt_pkg::HLT_C1_SOURCE_LSB +: 3]),
		.rise_enable    (limit_control1[hlt_pkg::HLT_C1_RISE_EN_BIT]),
		.fall_enable    (limit_control1[hlt_pkg::HLT_C1_FALL_EN_BIT]),
		.rise_edge_mode (limit_control1[hlt_pkg::HLT_C1_RISE_EDGE_BIT]),
		.fall_edge_mode (limit_control1[hlt_pkg::HLT_C1_FALL_EDGE_BIT]),
		.reset_event    (cfg.ext_reset)
	);

	hlt_core u_core
	(
		.core_clk (core_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.sleep    (sleep),
		.cfg      (cfg)
	);
endmodule : hlt_top
`default_nettype wire

/* File: tb/hlt_checker_asserts.sv */
// checker: port-level properties of the limit timer
// assumes binding into hlt_top, one core_clk domain
`timescale 1ns/1ns
`default_nettype none
module hlt_checker
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        clk_en,
	input wire logic        sleep,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        limit_match,
	input wire logic        limit_irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic apb_wr;
	logic wr_cnt;
	logic wr_per;
	logic at_cnt;
	assign apb_wr = psel && penable && pwrite && clk_en;
	assign at_cnt = paddr == hlt_pkg::HLT_OFF_COUNT;
	assign wr_cnt = apb_wr && at_cnt;
	assign wr_per = apb_wr && paddr == hlt_pkg::HLT_OFF_PERIOD;
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	a_reset_quiet: assert property ($past(rst) |-> !limit_match && !limit_irq)
		else $error("match or irq after reset");
	a_reset_count: assert property ($past(rst) && at_cnt |-> prdata == 32'h0)
		else $error("count not zero after reset");
	a_count_write: assert property ($past(wr_cnt) && !$past(rst) && at_cnt
		|-> prdata == ($past(pwdata) & 32'h0000_00FF)) else $error("count write lost");
	a_period_write: assert property ($past(wr_per) && !$past(rst)
		&& paddr == hlt_pkg::HLT_OFF_PERIOD |-> prdata == ($past(pwdata) & 32'h0000_00FF))
		else $error("period write lost");
	a_sleep_hold: assert property (sleep && $past(sleep) && !$past(rst) && at_cnt
		&& $past(at_cnt) && !$past(wr_cnt) |-> $stable(prdata)) else $error("count moved asleep");
	a_upper_zero: assert property (psel && (at_cnt || paddr == hlt_pkg::HLT_OFF_PERIOD)
		|-> prdata[31:8] == 24'h0) else $error("upper bits set");
	a_ready_high: assert property (psel && penable |-> pready)
		else $error("no ready");
	a_bad_addr: assert property (psel && penable && paddr > 8'h14
		|-> pslverr && prdata == 32'h0) else $error("unmapped access accepted");
	a_irq_cause: assert property ($rose(limit_irq) |-> $past(limit_match) || $past(apb_wr))
		else $error("irq without match");
	c_count_write: cover property (wr_cnt);
	c_irq: cover property ($rose(limit_irq));
	c_match_end: cover property (limit_match ##1 !limit_match);
endmodule : hlt_checker
bind hlt_top hlt_checker i_chk (.*);
`default_nettype wire

/* File: tb/hlt_src_model.sv */
// model: six peripheral reset sources facing the limit timer
// assumes sel and lvl set by the bench
`timescale 1ns/1ns
`default_nettype none
module hlt_src_model
(
	input  wire logic       core_clk,
	input  wire logic [2:0] sel,
	input  wire logic       lvl,
	output logic      [5:0] src
);
	initial src = 6'h15;
	// unselected lines toggle so a wrong pick shows
	always @(posedge core_clk)
	begin
		for (int i = 0; i < 6; i++)
		begin
			src[i] <= (sel == 3'(i)) ? lvl : ~src[i];
		end
	end
endmodule : hlt_src_model
`default_nettype wire

/* File: tb/tb.sv */
// bench: apb-driven checks of the limit timer
// assumes hlt_top, checker and source model compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        clk_en = 1'b1;
	logic        sleep = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        limit_match;
	logic        limit_irq;
	logic [2:0]  src_sel = 3'h0;
	logic        src_lvl = 1'b0;
	logic [5:0]  src;
	logic [31:0] q;
	logic        err;
	logic [6:0]  c0s [6] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h18, 7'h78};
	int          exps [6] = '{1, 4, 16, 64, 4, 16};
	int          n_errors = 0;
	int          check_count = 0;
	int          n_match = 0;
	int          m0;
	hlt_src_model i_src (.core_clk(core_clk), .sel(src_sel), .lvl(src_lvl), .src(src));
	hlt_top i_dut (.*, .capture_compare_unit(src[0]), .comparator1_out(src[1]),
		.comparator2_out(src[2]), .output_generator_fault_pin(src[3]),
		.output_generator_out0(src[4]), .output_generator_out1(src[5]));
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) if (limit_match === 1'b1) n_match++;
	// ------------------------------------------------------------
	// bus tasks and scenarios
	// ------------------------------------------------------------
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		`CHK("register read", e, q)
	endtask : rd
	// match-high clock cycles counted from a cleared start until the flag rises
	task automatic scale_case(input logic [6:0] c0, input int exp);
		@(posedge core_clk);
		sleep <= 1'b1;
		wr(hlt_pkg::HLT_OFF_CONTROL0, {25'h0, c0});
		wr(hlt_pkg::HLT_OFF_INT_FLAG, 32'h0);
		wr(hlt_pkg::HLT_OFF_COUNT, 32'h0);
		@(negedge core_clk);
		m0 = n_match;
		@(posedge core_clk);
		sleep <= 1'b0;
		for (int i = 0; i < 3000 && limit_irq !== 1'b1; i++) @(negedge core_clk);
		`CHK("matches to flag", exp, n_match - m0)
	endtask : scale_case
	task automatic src_case(input logic [6:0] c1, input logic lv, input logic runs);
		@(posedge core_clk);
		src_sel <= c1[2:0];
		src_lvl <= lv;
		wr(hlt_pkg::HLT_OFF_CONTROL1, {25'h0, c1});
		wr(hlt_pkg::HLT_OFF_COUNT, 32'h1);
		@(negedge core_clk);
		m0 = n_match;
		repeat (20) @(negedge core_clk);
		`CHK("timer running", runs, n_match != m0)
	endtask : src_case
	task automatic finish_test;
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		finish_test();
	end
	initial
	begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		rd(hlt_pkg::HLT_OFF_COUNT, 32'h0);
		rd(hlt_pkg::HLT_OFF_PERIOD, 32'hFF);
		rd(hlt_pkg::HLT_OFF_CONTROL0, 32'h0);
		rd(hlt_pkg::HLT_OFF_CONTROL1, 32'h0);
		rd(hlt_pkg::HLT_OFF_INT_FLAG, 32'h0);
		rd(hlt_pkg::HLT_OFF_INT_EN, 32'h0);
		rd(8'h18, 32'h0);
		`CHK("unmapped error", 1'b1, err)
		wr(hlt_pkg::HLT_OFF_PERIOD, 32'hFFFF_FFA5);
		rd(hlt_pkg::HLT_OFF_PERIOD, 32'hA5);
		wr(hlt_pkg::HLT_OFF_COUNT, 32'h5A);
		wr(hlt_pkg::HLT_OFF_CONTROL1, 32'h7F);
		rd(hlt_pkg::HLT_OFF_CONTROL1, 32'h7F);
		wr(hlt_pkg::HLT_OFF_CONTROL0, 32'h7B);
		rd(hlt_pkg::HLT_OFF_COUNT, 32'h5A);
		clk_en <= 1'b0;
		wr(hlt_pkg::HLT_OFF_PERIOD, 32'h33);
		clk_en <= 1'b1;
		rd(hlt_pkg::HLT_OFF_PERIOD, 32'hA5);
		wr(hlt_pkg::HLT_OFF_CONTROL1, 32'h0);
		wr(hlt_pkg::HLT_OFF_PERIOD, 32'h2);
		wr(hlt_pkg::HLT_OFF_INT_EN, 32'h1);
		foreach (c0s[i]) scale_case(c0s[i], exps[i]);
		wr(hlt_pkg::HLT_OFF_INT_EN, 32'h0);
		@(negedge core_clk);
		`CHK("irq masked", 1'b0, limit_irq)
		rd(hlt_pkg::HLT_OFF_INT_FLAG, 32'h1);
		wr(hlt_pkg::HLT_OFF_CONTROL0, 32'h0);
		for (int k = 0; k < 6; k++) src_case(7'h08 | 7'(k), 1'b1, 1'b0);
		src_case(7'h0E, 1'b1, 1'b1);
		src_case(7'h0F, 1'b1, 1'b1);
		src_case(7'h10, 1'b0, 1'b0);
		src_case(7'h08, 1'b0, 1'b1);
		src_case(7'h28, 1'b1, 1'b1);
		src_case(7'h50, 1'b0, 1'b1);
		finish_test();
	end
endmodule : tb
`default_nettype wire
